// ==== bench/host_serial_model.sv ====
// host model driving the serial programming pins
`default_nettype none
module host_serial_model (
    // clock
    input  wire logic MCLK,
    // serial pins
    output var logic  SCLK,
    output var logic  SDATA,
    output var logic  SLE,
    output var logic  SCE
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        SCLK = 1'b0;
        SDATA = 1'b0;
        SLE = 1'b0;
        SCE = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    // data flips after a frame so a stale bit is never mistaken for a fresh one
    task automatic write_word(input vco_cfg_pkg::word_t w);
        SCE = 1'b1;
        for (int i = 31; i >= 0; i--) begin
            SDATA = w[i];
            wait_cyc(2);
            SCLK = 1'b1;
            wait_cyc(2);
            SCLK = 1'b0;
        end
        SLE = 1'b1;
        wait_cyc(2);
        SLE = 1'b0;
        wait_cyc(1);
        SCE = 1'b0;
        SDATA = ~SDATA;
    endtask
    task automatic clock_out();
        SCE = 1'b1;
        SCLK = 1'b1;
        wait_cyc(2);
        SCLK = 1'b0;
        wait_cyc(4);
    endtask
endmodule // host_serial_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// testbench for the radar vco configuration block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        MCLK, NRST, SCLK, SDATA, SLE, SCE, DOUT, REF_IN, LO_ENABLE, VCO_ENABLE, VCO_CAL, TX1_CAL, TX2_CAL;
    logic        TRANSMIT_CHANNEL_ONE, TRANSMIT_CHANNEL_TWO, TX_CONFLICT, ADC_ENABLE, ADC_START, ANALOG_PROBE_PIN;
    logic        ADC_FROM_TESTBUS, INT_ILLEGAL, RDIV_ILLEGAL, PFD_TICK, CAL_TICK, COUNTER_RESET;
    logic [7:0]  ADC_RESULT;
    logic [11:0] INT_VALUE;
    logic [24:0] FRAC_VALUE;
    logic [31:0] SETUP_NINE, SETUP_TEN;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n_adc_start = 0;
    logic [31:0] init_w [21] = '{32'h02000007, 32'h0000002B, 32'h0000000B, 32'h1D32A64A, 32'h2A20B929,
        32'h40003E88, 32'h809FE520, 32'h011F4827, 32'h00000006, 32'h01E28005, 32'h00200004,
        32'h01890803, 32'h00020642, 32'hFFF7FFE1, 32'h809FE720, 32'h809FE560, 32'h809FED60,
        32'h809FE5A0, 32'h809FF5A0, 32'h2800B929, 32'h809F25A0};
    radar_vco_config_sequencer i_radar_vco_config_sequencer (.MCLK, .NRST, .SCLK, .SDATA, .SLE, .SCE, .DOUT,
        .REF_IN, .ADC_RESULT, .LO_ENABLE, .TRANSMIT_CHANNEL_ONE, .TRANSMIT_CHANNEL_TWO, .TX_CONFLICT, .VCO_ENABLE,
        .VCO_CAL, .TX1_CAL, .TX2_CAL, .ADC_ENABLE, .ADC_START, .ANALOG_PROBE_PIN, .ADC_FROM_TESTBUS, .INT_VALUE,
        .INT_ILLEGAL, .FRAC_VALUE, .RDIV_ILLEGAL, .PFD_TICK, .CAL_TICK, .COUNTER_RESET, .SETUP_NINE, .SETUP_TEN);
    host_serial_model i_host_serial_model (.MCLK, .SCLK, .SDATA, .SLE, .SCE);
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    task automatic finish_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            $display("FAIL %0t timeout", $time);
            finish_test();
        end
    end
    // the start pulse stands while the host task is still busy on the pins
    always @(negedge MCLK) begin
        if (ADC_START === 1'b1) begin
            n_adc_start++;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        total_checks++;
        if (v < lo || v > hi) begin
            n_fail++;
            $display("FAIL %0t count %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    // pins follow three cycles after the strobe, four gives margin
    task automatic wr(input logic [31:0] w);
        i_host_serial_model.write_word(w);
        repeat (4) @(negedge MCLK);
    endtask
    task automatic count_ticks(input int edges, output int np, output int nc);
        np = 0;
        nc = 0;
        for (int e = 0; e < 2 * edges + 2; e++) begin
            REF_IN = (e < 2 * edges) ? ~REF_IN : 1'b0;
            repeat (4) begin
                @(negedge MCLK);
                np += (PFD_TICK === 1'b1);
                nc += (CAL_TICK === 1'b1);
            end
        end
    endtask
    task automatic t_init();
        for (int i = 0; i < 21; i++) begin
            wr(init_w[i]);
            if (i == 1) chk(COUNTER_RESET, 1'b1);
            if (i == 2) chk(COUNTER_RESET, 1'b0);
            if (i == 4) chk(SETUP_TEN, 32'h1D32A64A);
            if (i == 6) chk({LO_ENABLE, VCO_ENABLE, TRANSMIT_CHANNEL_ONE, ADC_ENABLE}, 4'b1101);
            if (i == 14) chk(VCO_CAL, 1'b1);
            if (i == 16) chk({TRANSMIT_CHANNEL_ONE, TX1_CAL}, 2'b11);
            if (i == 18) chk({TRANSMIT_CHANNEL_TWO, TX2_CAL, TRANSMIT_CHANNEL_ONE}, 3'b110);
        end
        chk(INT_VALUE, init_w[9][28:17]);
        chk(FRAC_VALUE, {init_w[9][16:5], init_w[8][17:5]});
        chk({INT_ILLEGAL, RDIV_ILLEGAL, TX2_CAL}, 3'b000);
        wr(32'h12345681);
        wr(32'hDEADBEEC);
        chk(SETUP_NINE, 32'h2800B929);
    endtask
    // recalibration after a temperature shift reuses the calibration steps
    task automatic t_recal();
        wr(32'h809FE520);
        chk({LO_ENABLE, TRANSMIT_CHANNEL_ONE, TRANSMIT_CHANNEL_TWO}, 3'b100);
        wr(32'h2A20B929);
        chk(SETUP_NINE, 32'h2A20B929);
        wr(32'hFFF7FFE1);
        wr(32'h809FE720);
        wr(32'h809FE560);
        wr(32'h809FED60);
        wr(32'h809FE5A0);
        chk({TRANSMIT_CHANNEL_ONE, TRANSMIT_CHANNEL_TWO, TX_CONFLICT}, 3'b010);
        wr(32'h809FF5A0);
        wr(32'h2800B929);
        chk(SETUP_NINE, 32'h2800B929);
        wr(32'h809F25A0);
        chk({TX2_CAL, TRANSMIT_CHANNEL_TWO, LO_ENABLE}, 3'b011);
    endtask
    task automatic t_tx();
        wr(32'h809FE5E0);
        chk({TRANSMIT_CHANNEL_ONE, TRANSMIT_CHANNEL_TWO, TX_CONFLICT}, 3'b001);
        wr(32'h809FE560);
        chk({TRANSMIT_CHANNEL_ONE, TRANSMIT_CHANNEL_TWO, TX_CONFLICT}, 3'b100);
    endtask
    task automatic t_temp();
        int n;
        n = n_adc_start;
        wr(32'h0000A064);
        chk({ANALOG_PROBE_PIN, ADC_FROM_TESTBUS}, 2'b10);
        wr(32'h809FA5A0);
        wr(32'h00012064);
        chk({ANALOG_PROBE_PIN, ADC_FROM_TESTBUS}, 2'b01);
        i_host_serial_model.write_word(32'h00028C82);
        repeat (6) @(negedge MCLK);
        rng(n_adc_start - n, 1, 1);
        ADC_RESULT = 8'hA5;
        wr(32'h018902C3);
        for (int i = 7; i >= 0; i--) begin
            chk(DOUT, ADC_RESULT[i]);
            i_host_serial_model.clock_out();
        end
        chk(DOUT, 1'b0);
    endtask
    task automatic t_ticks();
        int np, nc;
        wr(32'h809FE520);
        wr(32'h00000088);
        count_ticks(40, np, nc);
        rng(np, 19, 21);
        rng(nc, 4, 6);
        wr(32'h011F4427);
        count_ticks(20, np, nc);
        rng(np, 39, 41);
        wr(32'h011F4067);
        count_ticks(30, np, nc);
        rng(np, 9, 11);
        wr(32'h0000002B);
        count_ticks(10, np, nc);
        rng(np + nc, 0, 0);
        wr(32'h0000000B);
        wr(32'h011F4007);
        chk(RDIV_ILLEGAL, 1'b1);
        count_ticks(10, np, nc);
        rng(np, 0, 0);
        wr(32'h02000007);
        chk({LO_ENABLE, INT_ILLEGAL, RDIV_ILLEGAL, TRANSMIT_CHANNEL_ONE}, 4'b0100);
        chk(SETUP_NINE, 32'h00000000);
    endtask
    initial begin
        NRST = 1'b0;
        REF_IN = 1'b0;
        ADC_RESULT = 8'h00;
        repeat (8) @(negedge MCLK);
        NRST = 1'b1;
        @(negedge MCLK);
        chk({INT_ILLEGAL, LO_ENABLE, COUNTER_RESET, RDIV_ILLEGAL}, 4'b1000);
        t_init();
        t_recal();
        t_tx();
        t_temp();
        t_ticks();
        finish_test();
    end
endmodule // tb_top
bind radar_vco_config_sequencer vco_cfg_asserts i_vco_cfg_asserts (.MCLK, .NRST, .SCE, .TRANSMIT_CHANNEL_ONE,
    .TRANSMIT_CHANNEL_TWO, .TX_CONFLICT, .ADC_START, .LO_ENABLE, .INT_VALUE, .INT_ILLEGAL, .RDIV_ILLEGAL,
    .PFD_TICK, .CAL_TICK, .COUNTER_RESET, .SETUP_NINE);
`default_nettype wire

// ==== bench/vco_cfg_asserts.sv ====
// port assertions for the vco configuration block
`default_nettype none
module vco_cfg_asserts (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        NRST,
    // observed pins
    input wire logic        SCE,
    input wire logic        TRANSMIT_CHANNEL_ONE,
    input wire logic        TRANSMIT_CHANNEL_TWO,
    input wire logic        TX_CONFLICT,
    input wire logic        ADC_START,
    input wire logic        LO_ENABLE,
    input wire logic [11:0] INT_VALUE,
    input wire logic        INT_ILLEGAL,
    input wire logic        RDIV_ILLEGAL,
    input wire logic        PFD_TICK,
    input wire logic        CAL_TICK,
    input wire logic        COUNTER_RESET,
    input wire logic [31:0] SETUP_NINE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // flag is registered in the same cycle as the value; judge only once settled
    sequence int_settled;
        $stable(INT_VALUE) [*3];
    endsequence
    // six idle samples cover the three-cycle write pipeline
    sequence bus_idle;
        (!SCE) [*6];
    endsequence
    a_tx_one_only: assert property (!(TRANSMIT_CHANNEL_ONE && TRANSMIT_CHANNEL_TWO))
        else $error("both transmit channels powered");
    a_conflict_powers_off: assert property (TX_CONFLICT |-> !TRANSMIT_CHANNEL_ONE && !TRANSMIT_CHANNEL_TWO)
        else $error("channel powered during conflict");
    a_adc_start_pulse: assert property (ADC_START |=> !ADC_START)
        else $error("adc start longer than one cycle");
    a_cntrst_quiet: assert property (COUNTER_RESET && $past(COUNTER_RESET, 2) |-> !PFD_TICK && !CAL_TICK)
        else $error("tick while counters held");
    a_rdiv_zero_halts: assert property (RDIV_ILLEGAL && $past(RDIV_ILLEGAL, 2) |-> !PFD_TICK)
        else $error("tick with zero ratio");
    a_int_limit: assert property (int_settled |-> INT_ILLEGAL == (INT_VALUE < 12'h04B))
        else $error("integer legality flag wrong");
    a_idle_no_change: assert property (bus_idle |-> $stable(SETUP_NINE) && $stable(LO_ENABLE))
        else $error("register changed without a write");
    a_pfd_single: assert property (PFD_TICK |=> !PFD_TICK)
        else $error("reference tick too long");
    a_cal_single: assert property (CAL_TICK |=> !CAL_TICK)
        else $error("calibration tick too long");
endmodule // vco_cfg_asserts
`default_nettype wire

// ==== common/vco_cfg_pkg.sv ====
// types shared by the vco configuration block
`default_nettype none
package vco_cfg_pkg;
    typedef logic [31:0] word_t;
    typedef logic [4:0]  sel_t;
    typedef enum logic [1:0] {
        RB_IDLE  = 2'b00,
        RB_SHIFT = 2'b01,
        RB_DONE  = 2'b10
    } rb_state_t;
endpackage
`default_nettype wire

// ==== common/vco_cfg_regs.svh ====
// register selects, field positions and reset values of the vco configuration block
`ifndef VCO_CFG_REGS_SVH
`define VCO_CFG_REGS_SVH
`define SEL_LSB        0
`define SEL_MSB        4
`define SEL_POWER      5'h00
`define SEL_ADC        5'h02
`define SEL_READBACK   5'h03
`define SEL_TESTBUS    5'h04
`define SEL_FRAC_MSB   5'h05
`define SEL_FRAC_LSB   5'h06
`define SEL_REFSETUP   5'h07
`define SEL_CALDIV     5'h08
`define SEL_NINE       5'h09
`define SEL_TEN        5'h0A
`define SEL_CNTRST     5'h0B
`define PWR_LO         5
`define PWR_TX1        6
`define PWR_TX2        7
`define PWR_ADC        8
`define PWR_VCOCAL     9
`define PWR_VCO        10
`define PWR_TX1CAL     11
`define PWR_TX2CAL     12
`define PWR_NCNT       14
`define PWR_RCNT       15
`define ADC_START_BIT  15
`define RB_MSB         10
`define RB_LSB         5
`define RB_ADC_CODE    6'h16
`define TB_SEL_MSB     14
`define TB_SEL_LSB     5
`define TB_TO_PIN      15
`define TB_TO_ADC      16
`define TB_TEMP_CODE   10'h103
`define INT_MSB        28
`define INT_LSB        17
`define FMSB_MSB       16
`define FMSB_LSB       5
`define FLSB_MSB       17
`define FLSB_LSB       5
`define FLSB_WIDTH     13
`define INT_MIN        12'h04B
`define RDIV_MSB       9
`define RDIV_LSB       5
`define RDIV_DOUBLER   10
`define RDIV_HALVING   11
`define MASTER_RST     25
`define CALDIV_MSB     14
`define CALDIV_LSB     5
`define CNTRST_BIT     5
`define PWR_MSB        15
`define PWR_LSB        0
`define RB_LAST_BIT    3'h7
`define RDIV_RESET     5'h01
`define CALDIV_RESET   10'h001
`define WORD_RESET     32'h00000000
`endif

// ==== common/word_bus_if.sv ====
// words and serial clock events passed from the shift front end to the core
`default_nettype none
interface word_bus_if;
    logic                 word_valid;
    vco_cfg_pkg::word_t   word;
    logic                 sclk_fall;
    modport rx   (output word_valid, output word, output sclk_fall);
    modport core (input word_valid, input word, input sclk_fall);
endinterface
`default_nettype wire

// ==== rtl/radar_vco_config_sequencer.sv ====
// register bank, reference and calibration dividers and readback of the radar vco
`default_nettype none
`include "vco_cfg_regs.svh"
module radar_vco_config_sequencer (
    // clock and reset
    input  wire logic          MCLK,
    input  wire logic          NRST,
    // serial programming pins
    input  wire logic          SCLK,
    input  wire logic          SDATA,
    input  wire logic          SLE,
    input  wire logic          SCE,
    output logic               DOUT,
    // analog side
    input  wire logic          REF_IN,
    input  wire logic [7:0]    ADC_RESULT,
    // power and calibration controls
    output logic               LO_ENABLE,
    output logic               TRANSMIT_CHANNEL_ONE,
    output logic               TRANSMIT_CHANNEL_TWO,
    output logic               TX_CONFLICT,
    output logic               VCO_ENABLE,
    output logic               VCO_CAL,
    output logic               TX1_CAL,
    output logic               TX2_CAL,
    output logic               ADC_ENABLE,
    output logic               ADC_START,
    // test bus routing
    output logic               ANALOG_PROBE_PIN,
    output logic               ADC_FROM_TESTBUS,
    // synthesis values and ticks
    output logic [11:0]        INT_VALUE,
    output logic               INT_ILLEGAL,
    output logic [24:0]        FRAC_VALUE,
    output logic               RDIV_ILLEGAL,
    output logic               PFD_TICK,
    output logic               CAL_TICK,
    output logic               COUNTER_RESET,
    output logic [31:0]        SETUP_NINE,
    output logic [31:0]        SETUP_TEN
);
    word_bus_if wb ();

    serial_word_rx u_rx (
        .MCLK  (MCLK),
        .NRST  (NRST),
        .SCLK  (SCLK),
        .SDATA (SDATA),
        .SLE   (SLE),
        .SCE   (SCE),
        .wb    (wb.rx)
    );

    function automatic logic wr_hit(input logic valid, input vco_cfg_pkg::word_t w,
                                    input vco_cfg_pkg::sel_t sel);
        wr_hit = valid && (w[`SEL_MSB:`SEL_LSB] == sel);
    endfunction

    // register state
    logic [15:0]               power_r;
    logic [5:0]                rb_code_r;
    logic                      tb_pin_r;
    logic                      tb_adc_r;
    logic [9:0]                tb_sel_r;
    logic [11:0]               int_r;
    logic [11:0]               fmsb_r;
    logic [12:0]               flsb_r;
    logic [4:0]                rdiv_r;
    logic                      dbl_r;
    logic                      half_r;
    logic [9:0]                caldiv_r;
    logic                      cnt_rst_r;
    logic                      adc_start_r;
    vco_cfg_pkg::word_t        nine_r;
    vco_cfg_pkg::word_t        ten_r;

    // write decode
    logic                      wr_power;
    logic                      wr_adc;
    logic                      wr_rb;
    logic                      wr_tb;
    logic                      wr_fmsb;
    logic                      wr_flsb;
    logic                      wr_ref;
    logic                      wr_cal;
    logic                      wr_nine;
    logic                      wr_ten;
    logic                      wr_cnt;
    logic                      master_rst;
    vco_cfg_pkg::word_t        w;

    assign w          = wb.word;
    assign wr_power   = wr_hit(wb.word_valid, w, `SEL_POWER);
    assign wr_adc     = wr_hit(wb.word_valid, w, `SEL_ADC);
    assign wr_rb      = wr_hit(wb.word_valid, w, `SEL_READBACK);
    assign wr_tb      = wr_hit(wb.word_valid, w, `SEL_TESTBUS);
    assign wr_fmsb    = wr_hit(wb.word_valid, w, `SEL_FRAC_MSB);
    assign wr_flsb    = wr_hit(wb.word_valid, w, `SEL_FRAC_LSB);
    assign wr_ref     = wr_hit(wb.word_valid, w, `SEL_REFSETUP);
    assign wr_cal     = wr_hit(wb.word_valid, w, `SEL_CALDIV);
    assign wr_nine    = wr_hit(wb.word_valid, w, `SEL_NINE);
    assign wr_ten     = wr_hit(wb.word_valid, w, `SEL_TEN);
    assign wr_cnt     = wr_hit(wb.word_valid, w, `SEL_CNTRST);
    assign master_rst = wr_ref && w[`MASTER_RST];

    // master reset returns every register to its reset value (ratio and calibration divider to 1), itself included, so it acts as one shot
    always_ff @(posedge MCLK) begin
        if (!NRST || master_rst) begin
            power_r     <= 16'h0000;
            rb_code_r   <= 6'h00;
            tb_pin_r    <= 1'b0;
            tb_adc_r    <= 1'b0;
            tb_sel_r    <= 10'h000;
            int_r       <= 12'h000;
            fmsb_r      <= 12'h000;
            flsb_r      <= 13'h0000;
            rdiv_r      <= `RDIV_RESET;
            dbl_r       <= 1'b0;
            half_r      <= 1'b0;
            caldiv_r    <= `CALDIV_RESET;
            cnt_rst_r   <= 1'b0;
            nine_r      <= `WORD_RESET;
            ten_r       <= `WORD_RESET;
        end else begin
            if (wr_power) begin
                power_r <= w[`PWR_MSB:`PWR_LSB];
            end
            if (wr_rb) begin
                rb_code_r <= w[`RB_MSB:`RB_LSB];
            end
            if (wr_tb) begin
                tb_pin_r <= w[`TB_TO_PIN];
                tb_adc_r <= w[`TB_TO_ADC];
                tb_sel_r <= w[`TB_SEL_MSB:`TB_SEL_LSB];
            end
            if (wr_fmsb) begin
                int_r  <= w[`INT_MSB:`INT_LSB];
                fmsb_r <= w[`FMSB_MSB:`FMSB_LSB];
            end
            if (wr_flsb) begin
                flsb_r <= w[`FLSB_MSB:`FLSB_LSB];
            end
            if (wr_ref) begin
                rdiv_r <= w[`RDIV_MSB:`RDIV_LSB];
                dbl_r  <= w[`RDIV_DOUBLER];
                half_r <= w[`RDIV_HALVING];
            end
            if (wr_cal) begin
                caldiv_r <= w[`CALDIV_MSB:`CALDIV_LSB];
            end
            if (wr_nine) begin
                nine_r <= w;
            end
            if (wr_ten) begin
                ten_r <= w;
            end
            if (wr_cnt) begin
                cnt_rst_r <= w[`CNTRST_BIT];
            end
        end
    end
    // reference divider chain
    logic                      ref_d_r;
    logic [4:0]                rcnt_r;
    logic [4:0]                rcnt_nxt;
    logic                      half_tgl_r;
    logic                      pfd_r;
    logic [9:0]                ccnt_r;
    logic [9:0]                ccnt_nxt;
    logic                      cal_r;
    logic                      ref_evt;
    logic                      r_wrap;
    logic                      pfd_nxt;
    logic                      c_wrap;
    logic                      cnt_hold;
    logic                      rdiv_bad;

    // doubler is done by counting both reference edges instead of rising only
    assign ref_evt  = dbl_r ? (REF_IN ^ ref_d_r) : (REF_IN & ~ref_d_r);
    assign rdiv_bad = (rdiv_r == 5'h00);
    // counters are held cleared while in reset, while the r counter is down or on a zero ratio
    assign cnt_hold = cnt_rst_r | ~power_r[`PWR_RCNT] | rdiv_bad;
    assign r_wrap   = ref_evt && (rcnt_r == rdiv_r - 5'h01);
    assign rcnt_nxt = r_wrap ? 5'h00 : (ref_evt ? rcnt_r + 5'h01 : rcnt_r);
    assign pfd_nxt  = r_wrap && (!half_r || half_tgl_r);
    assign c_wrap   = pfd_nxt && (ccnt_r >= caldiv_r - 10'h001);
    assign ccnt_nxt = c_wrap ? 10'h000 : (pfd_nxt ? ccnt_r + 10'h001 : ccnt_r);
    // adc start is a write-triggered pulse, not a stored level
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ref_d_r     <= 1'b0;
            adc_start_r <= 1'b0;
        end else begin
            ref_d_r     <= REF_IN;
            adc_start_r <= wr_adc && w[`ADC_START_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST || cnt_hold || master_rst) begin
            rcnt_r     <= 5'h00;
            half_tgl_r <= 1'b0;
            pfd_r      <= 1'b0;
            ccnt_r     <= 10'h000;
            cal_r      <= 1'b0;
        end else begin
            rcnt_r     <= rcnt_nxt;
            half_tgl_r <= r_wrap ? ~half_tgl_r : half_tgl_r;
            pfd_r      <= pfd_nxt;
            ccnt_r     <= ccnt_nxt;
            cal_r      <= c_wrap;
        end
    end

    // readback shifter: adc code loaded on the readback write, shifted on sclk falls
    vco_cfg_pkg::rb_state_t    rb_state_r;
    vco_cfg_pkg::rb_state_t    rb_state_nxt;
    logic [7:0]                rb_shift_r;
    logic [2:0]                rb_cnt_r;
    logic                      rb_load;
    logic                      dout_r;

    assign rb_load = wr_rb && (w[`RB_MSB:`RB_LSB] == `RB_ADC_CODE);

    always_comb begin
        rb_state_nxt = rb_state_r;
        case (rb_state_r)
            vco_cfg_pkg::RB_IDLE: begin
                if (rb_load) begin
                    rb_state_nxt = vco_cfg_pkg::RB_SHIFT;
                end
            end
            vco_cfg_pkg::RB_SHIFT: begin
                if (wb.sclk_fall && rb_cnt_r == `RB_LAST_BIT) begin
                    rb_state_nxt = vco_cfg_pkg::RB_DONE;
                end
            end
            vco_cfg_pkg::RB_DONE: begin
                if (rb_load) begin
                    rb_state_nxt = vco_cfg_pkg::RB_SHIFT;
                end
            end
            default: begin
                rb_state_nxt = vco_cfg_pkg::RB_IDLE;
            end
        endcase
    end

    // msb sits on the pin right after the load, each falling edge brings the next bit
    always_ff @(posedge MCLK) begin
        if (!NRST || master_rst) begin
            rb_state_r <= vco_cfg_pkg::RB_IDLE;
            rb_shift_r <= 8'h00;
            rb_cnt_r   <= 3'h0;
            dout_r     <= 1'b0;
        end else begin
            rb_state_r <= rb_state_nxt;
            if (rb_load) begin
                rb_shift_r <= {ADC_RESULT[6:0], 1'b0};
                rb_cnt_r   <= 3'h0;
                dout_r     <= ADC_RESULT[7];
            end else if (rb_state_r == vco_cfg_pkg::RB_SHIFT && wb.sclk_fall) begin
                rb_shift_r <= {rb_shift_r[6:0], 1'b0};
                rb_cnt_r   <= rb_cnt_r + 3'h1;
                dout_r     <= (rb_cnt_r == `RB_LAST_BIT) ? 1'b0 : rb_shift_r[7];
            end
        end
    end

    // registered outputs
    logic                      both_tx;
    logic                      temp_sel;
    logic [24:0]               frac_sum;

    // both channels requested: neither is powered and the conflict is flagged
    assign both_tx  = power_r[`PWR_TX1] & power_r[`PWR_TX2];
    assign temp_sel = (tb_sel_r == `TB_TEMP_CODE);
    assign frac_sum = {fmsb_r, {`FLSB_WIDTH{1'b0}}} + {12'h000, flsb_r};

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            {LO_ENABLE, TRANSMIT_CHANNEL_ONE, TRANSMIT_CHANNEL_TWO, TX_CONFLICT, VCO_ENABLE, VCO_CAL} <= 6'h00;
            {TX1_CAL, TX2_CAL, ADC_ENABLE, ADC_START, ANALOG_PROBE_PIN, ADC_FROM_TESTBUS} <= 6'h00;
            INT_VALUE            <= 12'h000;
            INT_ILLEGAL          <= 1'b1;
            FRAC_VALUE           <= 25'h0000000;
            {RDIV_ILLEGAL, PFD_TICK, CAL_TICK, COUNTER_RESET, DOUT} <= 5'h00;
            SETUP_NINE           <= `WORD_RESET;
            SETUP_TEN            <= `WORD_RESET;
        end else begin
            LO_ENABLE            <= power_r[`PWR_LO];
            TRANSMIT_CHANNEL_ONE <= power_r[`PWR_TX1] & ~both_tx;
            TRANSMIT_CHANNEL_TWO <= power_r[`PWR_TX2] & ~both_tx;
            TX_CONFLICT          <= both_tx;
            {VCO_ENABLE, VCO_CAL, TX1_CAL, TX2_CAL, ADC_ENABLE} <= {power_r[`PWR_VCO], power_r[`PWR_VCOCAL],
                power_r[`PWR_TX1CAL], power_r[`PWR_TX2CAL], power_r[`PWR_ADC]};
            ADC_START            <= adc_start_r;
            ANALOG_PROBE_PIN     <= tb_pin_r & temp_sel;
            ADC_FROM_TESTBUS     <= tb_adc_r;
            INT_VALUE            <= int_r;
            INT_ILLEGAL          <= (int_r < `INT_MIN);
            FRAC_VALUE           <= frac_sum;
            RDIV_ILLEGAL         <= rdiv_bad;
            PFD_TICK             <= pfd_r;
            CAL_TICK             <= cal_r;
            COUNTER_RESET        <= cnt_rst_r;
            SETUP_NINE           <= nine_r;
            SETUP_TEN            <= ten_r;
            DOUT                 <= dout_r;
        end
    end
endmodule // radar_vco_config_sequencer
`default_nettype wire

// ==== rtl/serial_word_rx.sv ====
// serial shift front end: 32-bit words, msb first, taken on the load strobe
`default_nettype none
`include "vco_cfg_regs.svh"
module serial_word_rx (
    // clock and reset
    input  wire logic   MCLK,
    input  wire logic   NRST,
    // serial pins
    input  wire logic   SCLK,
    input  wire logic   SDATA,
    input  wire logic   SLE,
    input  wire logic   SCE,
    // words to the core
    word_bus_if.rx      wb
);
    logic                sclk_d_r;
    logic                sle_d_r;
    vco_cfg_pkg::word_t  shift_r;
    vco_cfg_pkg::word_t  shift_nxt;
    logic                sclk_rise;
    logic                sle_rise;

    // pins are synchronous to MCLK, so one delay stage is enough for edges
    assign sclk_rise = SCLK & ~sclk_d_r & SCE;
    assign sle_rise  = SLE & ~sle_d_r & SCE;
    assign shift_nxt = sclk_rise ? {shift_r[30:0], SDATA} : shift_r;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            sclk_d_r      <= 1'b0;
            sle_d_r       <= 1'b0;
            shift_r       <= `WORD_RESET;
            wb.word       <= `WORD_RESET;
            wb.word_valid <= 1'b0;
            wb.sclk_fall  <= 1'b0;
        end else begin
            sclk_d_r      <= SCLK;
            sle_d_r       <= SLE;
            shift_r       <= shift_nxt;
            wb.word_valid <= sle_rise;
            wb.sclk_fall  <= ~SCLK & sclk_d_r & SCE;
            if (sle_rise) begin
                wb.word <= shift_r;
            end
        end
    end
endmodule // serial_word_rx
`default_nettype wire
